// ==== include/bdec_pkg.sv ====
// Purpose: shared constants and types for the debug entry controller
// Assumes: 32-bit scratch register, 16-bit opcodes
// Notes: vector offsets are byte offsets into the exception table
package bdec_pkg;
  localparam logic [15:0] OPC_ENTER_BG = 16'h4afa;
  localparam logic [15:0] OPC_SWBP_LO = 16'h4848;
  localparam logic [15:0] OPC_SWBP_HI = 16'h484f;
  localparam logic [3:0] OPC_LINE_A = 4'ha;
  localparam logic [3:0] OPC_LINE_F = 4'hf;
  localparam logic [15:0] SRC_ZERO = 16'h0000;
  localparam logic [15:0] SRC_OPCODE_LO = 16'h0001;
  localparam logic [15:0] SRC_DFAULT_LO = 16'hffff;
  localparam logic [31:0] PCC_RESET_FAULT = 32'hffffffff;
  localparam logic [31:0] SCRATCH_RST = 32'h00000000;
  localparam logic [9:0] VEC_ILLEGAL = 10'h010;
  localparam logic [9:0] VEC_TRACE = 10'h024;
  localparam logic [9:0] VEC_LINE_A = 10'h028;
  localparam logic [9:0] VEC_LINE_F = 10'h02c;
  localparam logic [9:0] VEC_BREAKPOINT_REQUEST_N = 10'h00c;
  localparam logic [9:0] VEC_NONE = 10'h000;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    BDEC_RUN = 3'b001,
    BDEC_HALTED = 3'b010,
    BDEC_FROZEN = 3'b100
  } bdec_state_t;

  // Events offered by the core in one cycle
  typedef struct packed {
    logic breakpoint_request_n_ack;
    logic opc_valid;
    logic [15:0] opcode;
    logic double_fault;
    logic reset_fetch;
    logic [15:0] special_status_word;
    logic insn_done;
    logic flow_change;
  } bdec_core_ev_t;

  // Answer to the core
  typedef struct packed {
    logic exc_valid;
    logic [9:0] exc_vector;
    logic halt_fatal;
    logic sub_opcode;
  } bdec_exc_t;
endpackage : bdec_pkg

// ==== logic/bdec_scratch.sv ====
// Purpose: entry source scratch word with registered read port
// Assumes: one writer port, entry load has priority over the write
// Notes: read data lags one cycle
`timescale 1ns/1ps
module bdec_scratch (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [31:0] load_data,
  input wire logic wr,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data
);
  logic [31:0] word_q;

  // Entry load beats a late command write
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      word_q <= bdec_pkg::SCRATCH_RST;
      rd_data <= bdec_pkg::SCRATCH_RST;
    end else begin
      if (load) begin
        word_q <= load_data;
      end else if (wr) begin
        word_q <= wr_data;
      end
      rd_data <= word_q;
    end
  end
endmodule : bdec_scratch

// ==== logic/bdec_sync.sv ====
// Purpose: two flop synchroniser for a pin level
// Assumes: destination is sys_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module bdec_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic meta_q;

  // Reset high so an idle pull-up line reads released
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : bdec_sync

// ==== logic/bdec_top.sv ====
// Purpose: decides debug entry versus exception per source
// Assumes: core presents events one cycle wide on sys_clk
// Notes: serial shifting and commands live elsewhere
`timescale 1ns/1ps
// How it works
// (R1) Low request at reset release arms debug
// (R2) High request at release disarms; resampled each reset
// (R3) Host holds request low two cycles first
// (R4) Host releases request before first bus cycle
// (R5) Acked request: debug if armed, else vector 0c
// (R6) No breakpoint acknowledge cycle on debug entry
// (R7) Enter-background opcode: debug or illegal instruction
// (R8) Double fault: debug if armed, else fatal halt
// (R9) Software breakpoint opcodes never enter debug
// (R10) Peripheral requests share the same line
// (R11) Halt indication first, then serial enable
// (R12) Scratch loaded with entry source code
// (R13) Host reads scratch first after entry
// (R14) Reset-fetch double fault sets pcc all ones
// (R15) Trace exception per instruction, optional flow-only
// (R16) Line A and F use own vectors
// (R17) Exit drops halt and serial together, then pins back
// (R18) In debug, pins carry serial clock and data
// (R19) Halt holds until exit; entries ignored meanwhile
module bdec_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic breakpoint_request_n,
  input wire logic fetch_status_pin,
  input wire bdec_pkg::bdec_core_ev_t core_ev,
  input wire logic trace_en,
  input wire logic trace_flow_only,
  input wire logic exit_cmd,
  input wire logic scratch_wr,
  input wire logic [31:0] scratch_wr_data,
  input wire logic serial_out_bit,
  input wire logic pipe_status_in,
  output bdec_pkg::bdec_exc_t exc_out,
  output logic halted,
  output logic serial_en,
  output logic debug_serial_clock,
  output logic debug_serial_in,
  output logic pipe_status_pin,
  output logic breakpoint_request_n_ack_cycle,
  output logic background_debug_mode,
  output logic pcc_set,
  output logic [31:0] pcc_value,
  output logic [31:0] entry_source_scratch
);
  logic req_n_s;
  logic fetch_s;
  logic nrst_q;
  logic armed_q;
  bdec_pkg::bdec_state_t state_q;
  bdec_pkg::bdec_state_t state_d;
  bdec_pkg::bdec_exc_t exc_d;
  logic [31:0] load_data;
  logic load_scratch;

  // Kept out of reset so the line is still tracked while reset is held
  bdec_sync u_sync_req (
    .sys_clk(sys_clk),
    .nrst(1'b1),
    .din(breakpoint_request_n),
    .dout(req_n_s)
  );

  bdec_sync u_sync_fetch (
    .sys_clk(sys_clk),
    .nrst(1'b1),
    .din(fetch_status_pin),
    .dout(fetch_s)
  );

  // Opcode classes
  function automatic logic is_swbp(input logic [15:0] op);
    is_swbp = (op >= bdec_pkg::OPC_SWBP_LO) && (op <= bdec_pkg::OPC_SWBP_HI);
  endfunction : is_swbp

  wire run = (state_q == bdec_pkg::BDEC_RUN);
  wire op_bg = core_ev.opc_valid && (core_ev.opcode == bdec_pkg::OPC_ENTER_BG); // R7
  wire op_swbp = core_ev.opc_valid && is_swbp(core_ev.opcode); // R9
  wire op_la = core_ev.opc_valid && (core_ev.opcode[15:12] == bdec_pkg::OPC_LINE_A);
  wire op_lf = core_ev.opc_valid && (core_ev.opcode[15:12] == bdec_pkg::OPC_LINE_F);
  // Same line serves external and peripheral requests
  wire bp_ev = core_ev.breakpoint_request_n_ack && !req_n_s; // R10
  wire ent_bp = run && armed_q && bp_ev; // R5
  wire ent_op = run && armed_q && op_bg; // R7
  wire ent_df = run && armed_q && core_ev.double_fault; // R8
  wire enter = ent_bp || ent_op || ent_df;
  wire trace_hit = trace_en && core_ev.insn_done && (!trace_flow_only || core_ev.flow_change);

  // Scratch code per source
  assign load_data = ent_df ? {core_ev.special_status_word, bdec_pkg::SRC_DFAULT_LO} :
                     ent_op ? {bdec_pkg::SRC_ZERO, bdec_pkg::SRC_OPCODE_LO} :
                     {bdec_pkg::SRC_ZERO, bdec_pkg::SRC_ZERO}; // R12
  assign load_scratch = enter; // R12

  // Arm latch follows the sampled line at reset release
  always_ff @(posedge sys_clk) begin
    nrst_q <= nrst;
    if (!nrst) begin
      armed_q <= 1'b0;
    end else if (!nrst_q) begin
      armed_q <= !req_n_s; // R1 R2
    end
  end

  // Entry state: halt raised, serial enabled the cycle after
  always_comb begin
    state_d = state_q;
    case (state_q)
      bdec_pkg::BDEC_RUN: begin
        if (enter) begin
          state_d = bdec_pkg::BDEC_HALTED; // R11
        end
      end
      bdec_pkg::BDEC_HALTED: begin
        state_d = bdec_pkg::BDEC_FROZEN; // R11
      end
      bdec_pkg::BDEC_FROZEN: begin
        if (exit_cmd) begin
          state_d = bdec_pkg::BDEC_RUN; // R17
        end
      end
      default: state_d = bdec_pkg::BDEC_RUN;
    endcase
  end

  // Exception answers when not entering debug
  always_comb begin
    exc_d = '0;
    exc_d.exc_vector = bdec_pkg::VEC_NONE;
    if (run && !enter) begin
      if (bp_ev) begin
        exc_d.exc_valid = 1'b1;
        exc_d.exc_vector = bdec_pkg::VEC_BREAKPOINT_REQUEST_N; // R5
      end else if (core_ev.double_fault) begin
        exc_d.halt_fatal = 1'b1; // R8
      end else if (op_swbp) begin
        exc_d.sub_opcode = 1'b1; // R9
        exc_d.exc_valid = 1'b1;
        exc_d.exc_vector = bdec_pkg::VEC_ILLEGAL;
      end else if (op_la) begin
        exc_d.exc_valid = 1'b1;
        exc_d.exc_vector = bdec_pkg::VEC_LINE_A; // R16
      end else if (op_lf) begin
        exc_d.exc_valid = 1'b1;
        exc_d.exc_vector = bdec_pkg::VEC_LINE_F; // R16
      end else if (op_bg) begin
        exc_d.exc_valid = 1'b1;
        exc_d.exc_vector = bdec_pkg::VEC_ILLEGAL; // R7
      end else if (trace_hit) begin
        exc_d.exc_valid = 1'b1;
        exc_d.exc_vector = bdec_pkg::VEC_TRACE; // R15
      end
    end
  end

  // State and registered outputs; entries ignored while halted
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= bdec_pkg::BDEC_RUN;
      exc_out <= '0;
      halted <= 1'b0;
      serial_en <= 1'b0;
      breakpoint_request_n_ack_cycle <= 1'b0;
      background_debug_mode <= 1'b0;
    end else begin
      state_q <= state_d; // R19
      exc_out <= exc_d;
      halted <= (state_d != bdec_pkg::BDEC_RUN); // R11 R17 R19
      serial_en <= (state_d == bdec_pkg::BDEC_FROZEN); // R11 R17
      breakpoint_request_n_ack_cycle <= bp_ev && !enter && run; // R6
      background_debug_mode <= armed_q;
    end
  end

  // Pin sharing: serial use only while serial is enabled
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      debug_serial_clock <= 1'b1;
      debug_serial_in <= 1'b0;
      pipe_status_pin <= 1'b0;
    end else begin
      debug_serial_clock <= serial_en ? req_n_s : 1'b1; // R18
      debug_serial_in <= serial_en ? fetch_s : 1'b0; // R18
      pipe_status_pin <= serial_en ? serial_out_bit : pipe_status_in; // R17 R18
    end
  end

  // Current pc marker for a fault during the reset fetch
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pcc_set <= 1'b0;
      pcc_value <= bdec_pkg::SCRATCH_RST;
    end else begin
      pcc_set <= ent_df && core_ev.reset_fetch; // R14
      pcc_value <= (ent_df && core_ev.reset_fetch) ? bdec_pkg::PCC_RESET_FAULT : pcc_value; // R14
    end
  end

  bdec_scratch u_scratch (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(load_scratch),
    .load_data(load_data),
    .wr(scratch_wr && !run),
    .wr_data(scratch_wr_data),
    .rd_data(entry_source_scratch)
  );

  // Checks
  property p_arm;
    @(posedge sys_clk) disable iff (!nrst)
      !$past(nrst) |-> ##1 (armed_q == !$past(req_n_s, 1));
  endproperty
  a_arm: assert property (p_arm) else $error("arm mismatch"); // R1
  property p_armhold;
    @(posedge sys_clk) disable iff (!nrst)
      $past(nrst_q) && nrst_q |-> $stable(armed_q);
  endproperty
  a_armhold: assert property (p_armhold) else $error("arm changed"); // R2
  property p_bkvec;
    @(posedge sys_clk) disable iff (!nrst)
      run && bp_ev && !armed_q |=> exc_out.exc_valid && exc_out.exc_vector == bdec_pkg::VEC_BREAKPOINT_REQUEST_N;
  endproperty
  a_bkvec: assert property (p_bkvec) else $error("breakpoint_request_n vector"); // R5
  property p_noack;
    @(posedge sys_clk) disable iff (!nrst) ent_bp |=> !breakpoint_request_n_ack_cycle;
  endproperty
  a_noack: assert property (p_noack) else $error("ack on entry"); // R6
  property p_bgill;
    @(posedge sys_clk) disable iff (!nrst)
      run && op_bg && !armed_q && !bp_ev && !core_ev.double_fault |=>
        exc_out.exc_vector == bdec_pkg::VEC_ILLEGAL;
  endproperty
  a_bgill: assert property (p_bgill) else $error("bg illegal"); // R7
  property p_dfhalt;
    @(posedge sys_clk) disable iff (!nrst)
      run && core_ev.double_fault && !armed_q && !bp_ev |=> exc_out.halt_fatal;
  endproperty
  a_dfhalt: assert property (p_dfhalt) else $error("df halt"); // R8
  property p_swbp;
    @(posedge sys_clk) disable iff (!nrst)
      run && op_swbp && !bp_ev && !core_ev.double_fault |=> !halted;
  endproperty
  a_swbp: assert property (p_swbp) else $error("swbp entered"); // R9
  property p_order;
    @(posedge sys_clk) disable iff (!nrst) enter |=> halted && !serial_en ##1 serial_en;
  endproperty
  a_order: assert property (p_order) else $error("entry order"); // R11
  property p_code;
    @(posedge sys_clk) disable iff (!nrst)
      ent_op |-> ##2 entry_source_scratch == {bdec_pkg::SRC_ZERO, bdec_pkg::SRC_OPCODE_LO};
  endproperty
  a_code: assert property (p_code) else $error("scratch code"); // R12
  property p_exit;
    @(posedge sys_clk) disable iff (!nrst)
      state_q == bdec_pkg::BDEC_FROZEN && exit_cmd |=> !halted && !serial_en;
  endproperty
  a_exit: assert property (p_exit) else $error("exit"); // R17
  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
      serial_en && !exit_cmd |=> halted && serial_en;
  endproperty
  a_hold: assert property (p_hold) else $error("halt dropped"); // R19
  property p_dfent;
    @(posedge sys_clk) disable iff (!nrst)
      ent_df |=> halted && !exc_out.halt_fatal;
  endproperty
  a_dfent: assert property (p_dfent) else $error("df entry"); // R8
  property p_dfcode;
    @(posedge sys_clk) disable iff (!nrst)
      ent_df |-> ##2 entry_source_scratch == {$past(core_ev.special_status_word, 2), bdec_pkg::SRC_DFAULT_LO};
  endproperty
  a_dfcode: assert property (p_dfcode) else $error("df scratch code"); // R12
  property p_pcc;
    @(posedge sys_clk) disable iff (!nrst)
      ent_df && core_ev.reset_fetch |=> pcc_set && pcc_value == bdec_pkg::PCC_RESET_FAULT;
  endproperty
  a_pcc: assert property (p_pcc) else $error("pcc marker"); // R14
  property p_linea;
    @(posedge sys_clk) disable iff (!nrst)
      run && op_la && !bp_ev && !core_ev.double_fault |=>
        exc_out.exc_valid && exc_out.exc_vector == bdec_pkg::VEC_LINE_A;
  endproperty
  a_linea: assert property (p_linea) else $error("line a vector"); // R16
  property p_sclk;
    @(posedge sys_clk) disable iff (!nrst)
      serial_en |=> debug_serial_clock == $past(req_n_s);
  endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock pin"); // R18
  property p_pipe;
    @(posedge sys_clk) disable iff (!nrst)
      !serial_en |=> pipe_status_pin == $past(pipe_status_in);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipe pin"); // R17
  c_bp: cover property (@(posedge sys_clk) ent_bp);
  c_df: cover property (@(posedge sys_clk) ent_df && core_ev.reset_fetch);
  c_exit: cover property (@(posedge sys_clk) serial_en ##1 !serial_en);
  c_op: cover property (@(posedge sys_clk) ent_op);
  c_refused: cover property (@(posedge sys_clk) halted && core_ev.double_fault);
endmodule : bdec_top

// ==== test/bdec_host_model.sv ====
// Purpose: development host driving the request line and serial data in
// Assumes: link clock of 125 ns, request line pulled high when idle
// Notes: behavioural; link clock stands still outside frames
`timescale 1ns/1ps
module bdec_host_model (
  input wire logic arm,
  input wire logic frame_en,
  input wire logic data_bit,
  output logic breakpoint_request_n,
  output logic fetch_status_pin
);
  logic sclk = 1'b1;
  // Edges kept off the sys_clk grid, so sampling never races them
  initial begin
    #0.3;
    forever begin
      #62.5;
      sclk = frame_en ? ~sclk : 1'b1;
    end
  end
  // Request held low through reset, dropped with it; peripherals share it
  assign breakpoint_request_n = frame_en ? sclk : ~arm;
  // Released data line inverts, so stale data cannot look valid
  assign fetch_status_pin = frame_en ? data_bit : ~data_bit;
endmodule : bdec_host_model

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the debug entry controller
// Assumes: events pulse one cycle, answers one edge later
// Notes: inputs change on the falling edge, except the host link clock, which runs off the sys_clk grid
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module testbench;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic arm = 1'b1;
  logic frame_en = 1'b0;
  logic data_bit = 1'b0;
  logic trace_en = 1'b0;
  logic trace_flow_only = 1'b0;
  logic exit_cmd = 1'b0;
  logic scratch_wr = 1'b0;
  logic serial_out_bit = 1'b0;
  logic pipe_status_in = 1'b0;
  logic [31:0] scratch_wr_data = 32'h0;
  bdec_pkg::bdec_core_ev_t core_ev = '0;
  bdec_pkg::bdec_exc_t exc_out;
  logic breakpoint_request_n, fetch_status_pin, halted, serial_en, debug_serial_clock;
  logic debug_serial_in, pipe_status_pin, breakpoint_request_n_ack_cycle, background_debug_mode, pcc_set;
  logic [31:0] pcc_value, entry_source_scratch;
  int miscompares = 0;
  int checks_done = 0;

  always #4 sys_clk = ~sys_clk;

  bdec_host_model i_bdec_host_model (.arm, .frame_en, .data_bit, .breakpoint_request_n,
    .fetch_status_pin);
  bdec_top i_bdec_top (.sys_clk, .nrst, .breakpoint_request_n, .fetch_status_pin, .core_ev,
    .trace_en, .trace_flow_only, .exit_cmd, .scratch_wr, .scratch_wr_data, .serial_out_bit,
    .pipe_status_in, .exc_out, .halted, .serial_en, .debug_serial_clock, .debug_serial_in,
    .pipe_status_pin, .breakpoint_request_n_ack_cycle, .background_debug_mode, .pcc_set, .pcc_value,
    .entry_source_scratch);

  task finish_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // Event stands for one rising edge; caller clears it after the last one
  task automatic fire(input bdec_pkg::bdec_core_ev_t ev);
    core_ev = ev;
    @(negedge sys_clk);
  endtask : fire

  task automatic exc(input logic v, input logic [9:0] vec);
    `CHK("exc_valid", v, exc_out.exc_valid);
    if (v) `CHK("exc_vector", vec, exc_out.exc_vector);
  endtask : exc

  task automatic do_reset(input logic a);
    arm = a;
    nrst = 1'b0;
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    arm = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : do_reset

  task leave;
    serial_out_bit = 1'b0;
    pipe_status_in = 1'b1;
    exit_cmd = 1'b1;
    @(negedge sys_clk);
    exit_cmd = 1'b0;
    `CHK("halt off", 1'b0, halted);
    `CHK("ser off", 1'b0, serial_en);
    @(negedge sys_clk);
    `CHK("pipe back", 1'b1, pipe_status_pin);
    pipe_status_in = 1'b0;
  endtask : leave

  // Serial pins during debug, link clock from the host
  task link;
    frame_en = 1'b1;
    data_bit = 1'b1;
    serial_out_bit = 1'b1;
    @(negedge breakpoint_request_n);
    repeat (4) @(negedge sys_clk);
    `CHK("sclk low", 1'b0, debug_serial_clock);
    `CHK("sdin 1", 1'b1, debug_serial_in);
    `CHK("sdout 1", 1'b1, pipe_status_pin);
    data_bit = 1'b0;
    serial_out_bit = 1'b0;
    @(posedge breakpoint_request_n);
    repeat (4) @(negedge sys_clk);
    `CHK("sclk high", 1'b1, debug_serial_clock);
    `CHK("sdin 0", 1'b0, debug_serial_in);
    `CHK("sdout 0", 1'b0, pipe_status_pin);
    frame_en = 1'b0;
  endtask : link

  task automatic t_disarmed;
    logic [15:0] ops [4] = '{16'h4afa, 16'ha123, 16'hf456, 16'h484a};
    logic [9:0] vecs [4] = '{bdec_pkg::VEC_ILLEGAL, bdec_pkg::VEC_LINE_A, bdec_pkg::VEC_LINE_F,
      bdec_pkg::VEC_ILLEGAL};
    bdec_pkg::bdec_core_ev_t ev;
    do_reset(1'b0);
    `CHK("armed", 1'b0, background_debug_mode);
    for (int i = 0; i < 4; i++) begin
      ev = '0;
      ev.opc_valid = 1'b1;
      ev.opcode = ops[i];
      fire(ev);
      exc(1'b1, vecs[i]);
      `CHK("run", 1'b0, halted);
    end
    `CHK("subst", 1'b1, exc_out.sub_opcode);
    core_ev = '0;
    arm = 1'b1;
    repeat (3) @(negedge sys_clk);
    ev = '0;
    ev.breakpoint_request_n_ack = 1'b1;
    fire(ev);
    arm = 1'b0;
    exc(1'b1, bdec_pkg::VEC_BREAKPOINT_REQUEST_N);
    `CHK("ack cycle", 1'b1, breakpoint_request_n_ack_cycle);
    trace_en = 1'b1;
    ev = '0;
    ev.insn_done = 1'b1;
    fire(ev);
    exc(1'b1, bdec_pkg::VEC_TRACE);
    trace_flow_only = 1'b1;
    fire(ev);
    exc(1'b0, bdec_pkg::VEC_NONE);
    ev.flow_change = 1'b1;
    fire(ev);
    exc(1'b1, bdec_pkg::VEC_TRACE);
    trace_en = 1'b0;
    trace_flow_only = 1'b0;
    ev = '0;
    ev.double_fault = 1'b1;
    fire(ev);
    core_ev = '0;
    `CHK("fatal", 1'b1, exc_out.halt_fatal);
    `CHK("no debug", 1'b0, halted);
  endtask : t_disarmed

  task automatic t_arm_enter_background_opcode;
    bdec_pkg::bdec_core_ev_t ev;
    do_reset(1'b1);
    `CHK("armed", 1'b1, background_debug_mode);
    ev = '0;
    ev.opc_valid = 1'b1;
    ev.opcode = bdec_pkg::OPC_ENTER_BG;
    fire(ev);
    core_ev = '0;
    `CHK("halted", 1'b1, halted);
    `CHK("ser late", 1'b0, serial_en);
    exc(1'b0, bdec_pkg::VEC_NONE);
    @(negedge sys_clk);
    `CHK("ser on", 1'b1, serial_en);
    `CHK("scratch", 32'h00000001, entry_source_scratch);
    ev = '0;
    ev.double_fault = 1'b1;
    ev.special_status_word = 16'h1234;
    fire(ev);
    core_ev = '0;
    `CHK("ignored", 1'b0, exc_out.halt_fatal);
    scratch_wr = 1'b1;
    scratch_wr_data = 32'h0bad0f0e;
    @(negedge sys_clk);
    scratch_wr = 1'b0;
    @(negedge sys_clk);
    `CHK("held", 1'b1, halted);
    `CHK("scr wr", 32'h0bad0f0e, entry_source_scratch);
    link();
    leave();
  endtask : t_arm_enter_background_opcode

  task automatic t_hw_breakpoint_request_n;
    bdec_pkg::bdec_core_ev_t ev;
    ev = '0;
    ev.breakpoint_request_n_ack = 1'b1;
    arm = 1'b1;
    repeat (3) @(negedge sys_clk);
    fire(ev);
    core_ev = '0;
    arm = 1'b0;
    `CHK("halted", 1'b1, halted);
    `CHK("no ack", 1'b0, breakpoint_request_n_ack_cycle);
    `CHK("no exc", 1'b0, exc_out.exc_valid);
    @(negedge sys_clk);
    `CHK("scratch", 32'h00000000, entry_source_scratch);
    leave();
  endtask : t_hw_breakpoint_request_n

  task automatic t_dfault;
    bdec_pkg::bdec_core_ev_t ev;
    ev = '0;
    ev.double_fault = 1'b1;
    ev.reset_fetch = 1'b1;
    ev.special_status_word = 16'h5a3c;
    fire(ev);
    core_ev = '0;
    `CHK("halted", 1'b1, halted);
    `CHK("pcc set", 1'b1, pcc_set);
    `CHK("pcc", 32'hffffffff, pcc_value);
    @(negedge sys_clk);
    `CHK("scratch", 32'h5a3cffff, entry_source_scratch);
    leave();
  endtask : t_dfault

  // Whole software breakpoint range, armed
  task automatic t_swbp;
    bdec_pkg::bdec_core_ev_t ev;
    for (int i = 0; i < 8; i++) begin
      ev = '0;
      ev.opc_valid = 1'b1;
      ev.opcode = bdec_pkg::OPC_SWBP_LO + 16'(i);
      fire(ev);
      `CHK("run", 1'b0, halted);
      `CHK("subst", 1'b1, exc_out.sub_opcode);
      exc(1'b1, bdec_pkg::VEC_ILLEGAL);
    end
    core_ev = '0;
  endtask : t_swbp

  initial begin
    @(negedge sys_clk);
    t_disarmed();
    t_arm_enter_background_opcode();
    t_hw_breakpoint_request_n();
    t_dfault();
    t_swbp();
    finish_test();
  end

  // Tests need under 500 cycles
  initial begin
    #(8 * 5000);
    miscompares++;
    finish_test();
  end
endmodule : testbench
